// ===== rtl/i2cm_top.sv
// What this block does
// R01: two selectable bit rates, slow or fast
// R02: bit rate divided down from bus clock
// R03: start: data falls while clock high
// R04: stop: data rises while clock high
// R05: data stable through clock high phase
// R06: start only at cycle begin or after byte
// R07: write sends start, two/three bytes, stop
// R08: 24-bit field register shifted out MSB first
// R09: first field bit zero picks direction
// R10: read: address, one byte in, nack, stop
// R11: completion raises interrupt to host
// R12: ack status reports all acknowledges seen
// R13: software mode drives pins directly
// R14: suppress stop ends without stop
// R15: software clears suppress stop at end
// R16: clock held low between sequence steps
// R17: single byte from first field, no start
// R18: direction latched at start, reused later
// R19: read ack bit follows byte-count control
// R20: single-byte read fills third field only
// R21: long writes continue without stop
// R22: release data on ninth clock, sample ack
// R23: new transfers ignored while busy
`timescale 1ns/10ps
`default_nettype none
module i2cm_top (
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // two-wire pins
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // completion
  output logic             transfer_done_irq
);

////////////////////////////////////////////////////////////////////////////////
  logic [23:0]          sh_r;
  i2cm_pkg::i2cm_ctl_t  ctl_r;
  i2cm_pkg::i2cm_state_t st_r;
  logic [2:0]           ctrl_r;
  logic                 dir_r;
  logic                 done_r;
  logic                 ack_err_r;
  logic [7:0]           qcnt_r;
  logic [1:0]           q_r;
  logic [3:0]           bit_r;
  logic [1:0]           txb_r;
  logic                 rxn_r;
  logic [1:0]           scl_sy_r;
  logic [1:0]           sda_sy_r;
  logic                 scl_s;
  logic                 sda_s;
  logic                 acc;
  logic                 wr_xfer;
  logic                 wr_ctrl;
  logic                 wr_stat;
  logic                 busy;
  logic                 hw_en;
  logic                 start_ok;
  logic                 tick;
  logic                 stall;
  logic [7:0]           qlim;
  logic                 scl_low;
  logic                 sda_low;
  logic                 rx_cur;
  logic                 byte_end;
  logic                 last_byte;

  function automatic logic known_ofs(input logic [7:0] a);
    known_ofs = (a == i2cm_pkg::XFER_OFS) || (a == i2cm_pkg::CTRL_OFS) ||
                (a == i2cm_pkg::STAT_OFS);
  endfunction : known_ofs

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sy_r <= 2'h3;
      sda_sy_r <= 2'h3;
    end else if (ce) begin
      scl_sy_r <= {scl_sy_r[0], scl_i};
      sda_sy_r <= {sda_sy_r[0], sda_i};
    end
  end
  assign scl_s = scl_sy_r[1];
  assign sda_s = sda_sy_r[1];

////////////////////////////////////////////////////////////////////////////////
// apb slave: one wait state, then pready
  assign acc     = psel && penable && pready;
  assign wr_xfer = acc && pwrite && (paddr == i2cm_pkg::XFER_OFS);
  assign wr_ctrl = acc && pwrite && (paddr == i2cm_pkg::CTRL_OFS);
  assign wr_stat = acc && pwrite && (paddr == i2cm_pkg::STAT_OFS);
  assign hw_en   = ctrl_r[i2cm_pkg::HWEN_BIT];
  assign busy    = (st_r != i2cm_pkg::ST_IDLE) && (st_r != i2cm_pkg::ST_HOLD);
  assign start_ok = wr_xfer && hw_en && !busy; // see R23

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (ce) begin
      if (psel && penable && !pready) begin
        pready  <= 1'b1;
        pslverr <= !known_ofs(paddr);
        prdata  <= 32'h00000000;
        if (!pwrite) begin
          if (paddr == i2cm_pkg::XFER_OFS) begin
            prdata <= {sh_r, 3'h0, ctl_r, 1'b0};
          end else if (paddr == i2cm_pkg::CTRL_OFS) begin
            prdata <= {29'h0, ctrl_r};
          end else if (paddr == i2cm_pkg::STAT_OFS) begin
            prdata <= {27'h0, sda_s, scl_s, busy, !ack_err_r, done_r};
          end
        end
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= i2cm_pkg::CTRL_RST;
    end else if (ce && wr_ctrl) begin
      ctrl_r <= pwdata[2:0];
    end
  end

////////////////////////////////////////////////////////////////////////////////
// bit timing
  assign qlim  = (ctl_r.rate ? i2cm_pkg::QTR_FAST : i2cm_pkg::QTR_SLOW) - 8'h01; // see R01
  assign stall = busy && (q_r == 2'h1) && !scl_s;
  assign tick  = (qcnt_r == qlim) && !stall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qcnt_r <= 8'h00;
    end else if (ce) begin
      if (start_ok || !busy || tick) begin
        qcnt_r <= 8'h00; // see R02
      end else if (!stall) begin
        qcnt_r <= qcnt_r + 8'h01;
      end
    end
  end

  assign rx_cur    = (txb_r == 2'h0);
  assign byte_end  = (st_r == i2cm_pkg::ST_BIT) && tick && (q_r == 2'h3) &&
                     (bit_r == i2cm_pkg::ACK_IDX);
  assign last_byte = rx_cur || ((txb_r == 2'h1) && !rxn_r);

////////////////////////////////////////////////////////////////////////////////
// line levels per phase
  always_comb begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    case (st_r)
      i2cm_pkg::ST_START: begin
        scl_low = (q_r == 2'h0) || (q_r == 2'h3); // see R03
        sda_low = q_r[1];
      end
      i2cm_pkg::ST_BIT: begin
        scl_low = (q_r == 2'h0) || (q_r == 2'h3);
        if (bit_r == i2cm_pkg::ACK_IDX) begin
          sda_low = rx_cur && ctl_r.w3bra; // see R19 see R22 see R10
        end else begin
          sda_low = !rx_cur && !sh_r[23]; // see R08 see R05
        end
      end
      i2cm_pkg::ST_STOP: begin
        scl_low = (q_r == 2'h0); // see R04
        sda_low = !q_r[1];
      end
      i2cm_pkg::ST_HOLD: begin
        scl_low = 1'b1; // see R16
        sda_low = 1'b0;
      end
      default: begin
        scl_low = 1'b0;
        sda_low = 1'b0;
      end
    endcase
  end

  // open drain: output level always low, enable pulls the line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_o  <= 1'b0;
      sda_o  <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else if (ce) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      if (hw_en) begin
        scl_oe <= scl_low;
        sda_oe <= sda_low;
      end else begin
        scl_oe <= !ctrl_r[i2cm_pkg::SWSCL_BIT]; // see R13
        sda_oe <= !ctrl_r[i2cm_pkg::SWSDA_BIT];
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
// sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r  <= i2cm_pkg::ST_IDLE;
      q_r   <= 2'h0;
      bit_r <= 4'h0;
      txb_r <= 2'h0;
      rxn_r <= 1'b0;
    end else if (ce) begin
      if (!hw_en) begin
        st_r <= i2cm_pkg::ST_IDLE;
      end else if (start_ok) begin
        q_r   <= 2'h0;
        bit_r <= 4'h0;
        if (pwdata[i2cm_pkg::NOS1B_BIT]) begin
          st_r  <= i2cm_pkg::ST_BIT; // see R17 see R21
          txb_r <= dir_r ? 2'h0 : 2'h1; // see R18
          rxn_r <= dir_r;
        end else begin
          st_r  <= i2cm_pkg::ST_START; // see R06
          rxn_r <= pwdata[i2cm_pkg::DB0_LSB]; // see R09
          if (pwdata[i2cm_pkg::DB0_LSB]) begin
            txb_r <= 2'h1; // see R10
          end else begin
            txb_r <= pwdata[i2cm_pkg::W3BRA_BIT] ? 2'h3 : 2'h2; // see R07
          end
        end
      end else if (tick) begin
        q_r <= q_r + 2'h1;
        if (q_r == 2'h3) begin
          case (st_r)
            i2cm_pkg::ST_START: begin
              st_r  <= i2cm_pkg::ST_BIT;
              bit_r <= 4'h0;
            end
            i2cm_pkg::ST_BIT: begin
              if (bit_r != i2cm_pkg::ACK_IDX) begin
                bit_r <= bit_r + 4'h1;
              end else begin
                bit_r <= 4'h0;
                if (rx_cur) begin
                  rxn_r <= 1'b0;
                end else begin
                  txb_r <= txb_r - 2'h1;
                end
                if (last_byte) begin
                  st_r <= ctl_r.nostop ? i2cm_pkg::ST_HOLD : i2cm_pkg::ST_STOP; // see R14
                end
              end
            end
            i2cm_pkg::ST_STOP: begin
              st_r <= i2cm_pkg::ST_IDLE;
            end
            default: begin
              st_r <= st_r;
            end
          endcase
        end
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
// data, direction and controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_r  <= i2cm_pkg::DATA_RST;
      ctl_r <= '0;
      dir_r <= 1'b0;
    end else if (ce) begin
      if (wr_xfer && !busy) begin
        sh_r  <= pwdata[31:8];
        ctl_r <= pwdata[4:1];
        if (hw_en && !pwdata[i2cm_pkg::NOS1B_BIT]) begin
          dir_r <= pwdata[i2cm_pkg::DB0_LSB]; // see R18
        end
      end else if ((st_r == i2cm_pkg::ST_BIT) && tick && (bit_r != i2cm_pkg::ACK_IDX)) begin
        if (rx_cur && (q_r == 2'h2)) begin
          sh_r[7:0] <= {sh_r[6:0], sda_s}; // see R20
        end else if (!rx_cur && (q_r == 2'h3)) begin
          sh_r <= {sh_r[22:0], 1'b0}; // see R08
        end
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
// acknowledge status and completion flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_err_r <= 1'b0;
    end else if (ce) begin
      if (start_ok) begin
        ack_err_r <= 1'b0;
      end else if ((st_r == i2cm_pkg::ST_BIT) && tick && (q_r == 2'h2) &&
                   (bit_r == i2cm_pkg::ACK_IDX) && !rx_cur && sda_s) begin
        ack_err_r <= 1'b1; // see R22 see R12
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
    end else if (ce) begin
      if ((byte_end && last_byte && ctl_r.nostop) ||
          ((st_r == i2cm_pkg::ST_STOP) && tick && (q_r == 2'h3))) begin
        done_r <= 1'b1; // see R11
      end else if (start_ok || (wr_stat && pwdata[i2cm_pkg::DONE_BIT])) begin
        done_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transfer_done_irq <= 1'b0;
    end else if (ce) begin
      transfer_done_irq <= done_r;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// assertions
  property p_start_cond;
    @(posedge pclk) disable iff (!presetn)
      ($rose(sda_oe) && !scl_oe && hw_en && $past(hw_en)) |-> $past(st_r) == i2cm_pkg::ST_START;
  endproperty
  a_start_cond: assert property (p_start_cond) else $error("sda fell with scl high outside start"); // see R03

  property p_stop_cond;
    @(posedge pclk) disable iff (!presetn)
      ($fell(sda_oe) && !scl_oe && hw_en && $past(hw_en)) |-> $past(st_r) == i2cm_pkg::ST_STOP;
  endproperty
  a_stop_cond: assert property (p_stop_cond) else $error("sda rose with scl high outside stop"); // see R04

  property p_sda_stable;
    @(posedge pclk) disable iff (!presetn)
      (hw_en && !scl_oe && !$past(scl_oe) && st_r == i2cm_pkg::ST_BIT &&
       $past(st_r) == i2cm_pkg::ST_BIT) |-> $stable(sda_oe);
  endproperty
  a_sda_stable: assert property (p_sda_stable) else $error("sda moved during scl high"); // see R05

  property p_hold_low;
    @(posedge pclk) disable iff (!presetn)
      (hw_en && st_r == i2cm_pkg::ST_HOLD && $past(st_r) == i2cm_pkg::ST_HOLD) |-> scl_oe;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("scl not held low in hold"); // see R16

  property p_done_end;
    @(posedge pclk) disable iff (!presetn)
      $rose(done_r) |-> (st_r == i2cm_pkg::ST_IDLE || st_r == i2cm_pkg::ST_HOLD) ##1 transfer_done_irq;
  endproperty
  a_done_end: assert property (p_done_end) else $error("done not tied to transfer end"); // see R11

  property p_busy_ignore;
    @(posedge pclk) disable iff (!presetn)
      (wr_xfer && busy && ce) |=> ($stable(ctl_r) && $stable(dir_r) &&
                                   !(st_r == i2cm_pkg::ST_START &&
                                     $past(st_r) != i2cm_pkg::ST_START));
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("write accepted while busy"); // see R23

  property p_dir_latch;
    @(posedge pclk) disable iff (!presetn)
      (start_ok && ce && !pwdata[i2cm_pkg::NOS1B_BIT]) |=> dir_r == $past(pwdata[i2cm_pkg::DB0_LSB]);
  endproperty
  a_dir_latch: assert property (p_dir_latch) else $error("direction not latched at start"); // see R09

  property p_rate;
    @(posedge pclk) disable iff (!presetn)
      busy |-> qcnt_r <= qlim;
  endproperty
  a_rate: assert property (p_rate) else $error("quarter counter past its limit"); // see R01

  property p_sw_pins;
    @(posedge pclk) disable iff (!presetn)
      (!hw_en && !$past(hw_en) && $past(ce)) |-> scl_oe == !$past(ctrl_r[i2cm_pkg::SWSCL_BIT]);
  endproperty
  a_sw_pins: assert property (p_sw_pins) else $error("scl not under software control"); // see R13

  property p_rx_ack;
    @(posedge pclk) disable iff (!presetn)
      (hw_en && ce && st_r == i2cm_pkg::ST_BIT && bit_r == i2cm_pkg::ACK_IDX && rx_cur)
        |=> sda_oe == $past(ctl_r.w3bra);
  endproperty
  a_rx_ack: assert property (p_rx_ack) else $error("read ack level wrong"); // see R19

  c_write_stop: cover property (@(posedge pclk) disable iff (!presetn)
    (st_r == i2cm_pkg::ST_STOP && !dir_r) ##1 st_r == i2cm_pkg::ST_IDLE);
  c_read_done: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(done_r) && dir_r);
  c_hold: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(st_r == i2cm_pkg::ST_HOLD));
  c_sw_mode: cover property (@(posedge pclk) disable iff (!presetn)
    !hw_en && $fell(scl_oe));

endmodule : i2cm_top
`default_nettype wire

// ===== rtl/i2cm_pkg.sv
package i2cm_pkg;
  // register byte offsets
  localparam logic [7:0] XFER_OFS   = 8'h00;
  localparam logic [7:0] CTRL_OFS   = 8'h04;
  localparam logic [7:0] STAT_OFS   = 8'h08;
  // transfer register fields
  localparam int DB0_LSB   = 24;
  localparam int DB1_LSB   = 16;
  localparam int DB2_LSB   = 8;
  localparam int RATE_BIT  = 4;
  localparam int W3BRA_BIT = 3;
  localparam int NOSTP_BIT = 2;
  localparam int NOS1B_BIT = 1;
  // control register fields
  localparam int HWEN_BIT  = 0;
  localparam int SWSCL_BIT = 1;
  localparam int SWSDA_BIT = 2;
  // status register fields
  localparam int DONE_BIT  = 0;
  localparam int ACKOK_BIT = 1;
  localparam int BUSY_BIT  = 2;
  localparam int SCLIN_BIT = 3;
  localparam int SDAIN_BIT = 4;
  // reset values
  localparam logic [2:0] CTRL_RST = 3'h7;
  localparam logic [23:0] DATA_RST = 24'h000000;
  // timing
  localparam int CLK_HZ  = 10000000;
  localparam int SLOW_HZ = 99200;
  localparam int FAST_HZ = 396800;
  localparam int QS_I = CLK_HZ / (4 * SLOW_HZ);
  localparam int QF_I = CLK_HZ / (4 * FAST_HZ);
  localparam logic [7:0] QTR_SLOW = 8'((QS_I < 1) ? 1 : QS_I);
  localparam logic [7:0] QTR_FAST = 8'((QF_I < 1) ? 1 : QF_I);
  localparam logic [3:0] ACK_IDX  = 4'h8;

  typedef struct packed {
    logic rate;
    logic w3bra;
    logic nostop;
    logic nos1b;
  } i2cm_ctl_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_BIT, ST_STOP, ST_HOLD
  } i2cm_state_t;
endpackage : i2cm_pkg

// ===== sim/i2cm_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
module i2cm_slave_model (
  // bus wires
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            scl_oe,
  output logic            sda_oe,
  // behaviour knobs
  input  wire logic       nack,
  input  wire logic       stretch,
  input  wire logic [7:0] rd_byte
);
  int         bitn    = 0;
  int         starts  = 0;
  int         stops   = 0;
  logic       tx      = 1'b0;
  logic       addr    = 1'b0;
  logic       mst_ack = 1'b0;
  logic [7:0] sh      = 8'h00;
  logic [7:0] got[$];

  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  ////////////////////////////////////////
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      starts++;
      bitn = -1;
      addr = 1'b1;
      tx   = 1'b0;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      stops++;
      tx = 1'b0;
    end
  end
  always @(posedge scl) begin
    if (bitn >= 0 && bitn < 8) sh = {sh[6:0], sda};
    if (bitn == 8) mst_ack = !sda;
  end
  // data only changes while the clock is low
  always @(negedge scl) begin
    // direction is decided only after the acknowledge of the address byte
    if (bitn == 8) begin
      bitn = 0;
      if (addr) begin
        tx   = sh[0];
        addr = 1'b0;
      end else if (tx && !mst_ack) begin
        tx = 1'b0;
      end
    end else begin
      bitn = bitn + 1;
    end
    if (bitn == 8) begin
      if (!tx) got.push_back(sh);
      sda_oe = !tx && !nack;
    end else begin
      sda_oe = tx && !rd_byte[7 - bitn];
    end
    // long enough to outlast the master's own low phase and force a wait
    if (stretch) begin
      scl_oe = 1'b1;
      #6000;
      scl_oe = 1'b0;
    end
  end
endmodule : i2cm_slave_model
`default_nettype wire

// ===== sim/i2c_master_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_master_sequencer_tb;
  logic        pclk     = 1'b0;
  logic        presetn  = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        scl_oe;
  logic        sda_oe;
  logic        s_scl_oe;
  logic        s_sda_oe;
  logic        scl_w;
  logic        sda_w;
  logic        irq;
  logic        scl_lv;
  logic        sda_lv;
  logic        nack     = 1'b0;
  logic        stretch  = 1'b0;
  logic [7:0]  rd_byte  = 8'h3c;
  logic [31:0] rd;
  logic [31:0] st;
  logic        err;
  int          failures = 0;
  int          checked  = 0;
  int          gap      = 0;
  int          s0       = 0;
  int          p0       = 0;
  time         last_rise = 0;

  // open-drain wires with pull-ups
  assign scl_w = !(scl_oe | s_scl_oe);
  assign sda_w = !(sda_oe | s_sda_oe);

  i2cm_top uut (
    .pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl_w), .scl_o(scl_lv), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_lv),
    .sda_oe(sda_oe),
    .transfer_done_irq(irq)
  );
  i2cm_slave_model sl (
    .scl(scl_w), .sda(sda_w), .scl_oe(s_scl_oe), .sda_oe(s_sda_oe),
    .nack(nack), .stretch(stretch), .rd_byte(rd_byte)
  );

  always #50 pclk = ~pclk;
  // bit period in cycles, measured between rises inside a byte
  always @(posedge scl_w) begin
    if (sl.bitn >= 1 && sl.bitn <= 8) gap = int'(($time - last_rise) / 100);
    last_rise = $time;
  end
  ////////////////////////////////////////
  task automatic stop_test;
    if (failures == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    chk("pready idle", 32'h0, {31'h0, pready});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_done;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 40000) begin
      @(posedge pclk);
      n++;
    end
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b0, i2cm_pkg::STAT_OFS, 32'h0);
    st = rd;
    apb(1'b1, i2cm_pkg::STAT_OFS, 32'h1);
    repeat (3) @(posedge pclk);
    chk("irq clear", 32'h0, {31'h0, irq});
  endtask : wait_done
  task automatic xfer(input logic [31:0] d);
    apb(1'b1, i2cm_pkg::XFER_OFS, d);
    wait_done;
  endtask : xfer
  function automatic logic [31:0] xw(input logic [7:0] b0, input logic [7:0] b1,
                                     input logic [7:0] b2, input i2cm_pkg::i2cm_ctl_t c);
    return {b0, b1, b2, 3'h0, c, 1'b0};
  endfunction : xw
  // bytes seen by the slave, then starts and stops since the last call
  task automatic chk_bytes(input logic [31:0] exp, input int n, input int ds, input int dp);
    chk("byte count", 32'(n), 32'(sl.got.size()));
    for (int i = 0; i < n; i++) chk("byte", {24'h0, exp[31-8*i -: 8]}, {24'h0, sl.got[i]});
    chk("starts", 32'(ds), 32'(sl.starts - s0));
    chk("stops", 32'(dp), 32'(sl.stops - p0));
    sl.got.delete();
    s0 = sl.starts;
    p0 = sl.stops;
  endtask : chk_bytes
  ////////////////////////////////////////
  initial begin
    #8000000;
    $display("mismatch watchdog expected finish seen hang");
    failures++;
    stop_test;
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, i2cm_pkg::CTRL_OFS, 32'h0);
    chk("ctrl reset", {29'h0, i2cm_pkg::CTRL_RST}, rd);
    chk("mapped err", 32'h0, {31'h0, err});
    apb(1'b0, i2cm_pkg::STAT_OFS, 32'h0);
    chk("stat reset", 32'((1 << i2cm_pkg::SDAIN_BIT) | (1 << i2cm_pkg::SCLIN_BIT) |
                          (1 << i2cm_pkg::ACKOK_BIT)), rd);
    apb(1'b1, 8'h0c, 32'hffffffff);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped data", 32'h0, rd);
    // lines settle from unknown at reset: drop what the slave saw then
    s0 = sl.starts;
    p0 = sl.stops;
    sl.got.delete();
    xfer(xw(8'ha0, 8'h5a, 8'hc3, 4'h4));
    chk_bytes(32'ha05ac300, 3, 1, 1);
    chk("ack ok", 32'h1, {31'h0, st[i2cm_pkg::ACKOK_BIT]});
    chk("slow bit", 32'h1, {31'h0, gap >= 100 && gap <= 106});
    nack = 1'b1;
    xfer(xw(8'ha2, 8'h11, 8'h22, 4'h8));
    nack = 1'b0;
    chk_bytes(32'ha2110000, 2, 1, 1);
    chk("ack missing", 32'h0, {31'h0, st[i2cm_pkg::ACKOK_BIT]});
    chk("fast bit", 32'h1, {31'h0, gap >= 24 && gap <= 30});
    apb(1'b1, i2cm_pkg::XFER_OFS, xw(8'ha0, 8'h01, 8'h02, 4'h4));
    apb(1'b0, i2cm_pkg::STAT_OFS, 32'h0);
    chk("busy", 32'h1, {31'h0, rd[i2cm_pkg::BUSY_BIT]});
    apb(1'b1, i2cm_pkg::XFER_OFS, xw(8'ha4, 8'hee, 8'hee, 4'h4));
    wait_done;
    chk_bytes(32'ha0010200, 3, 1, 1);
    xfer(xw(8'ha0, 8'h10, 8'h00, 4'h2));
    repeat (100) @(posedge pclk);
    chk("clock held", 32'h0, {31'h0, scl_w});
    chk_bytes(32'ha0100000, 2, 1, 0);
    stretch = 1'b1;
    xfer(xw(8'ha1, 8'h00, 8'h00, 4'h0));
    stretch = 1'b0;
    apb(1'b0, i2cm_pkg::XFER_OFS, 32'h0);
    chk("read byte", 32'h3c, {24'h0, rd[15:8]});
    chk("read nack", 32'h0, {31'h0, sl.mst_ack});
    chk_bytes(32'ha1000000, 1, 1, 1);
    xfer(xw(8'ha0, 8'h20, 8'h00, 4'h2));
    xfer(xw(8'h77, 8'h00, 8'h00, 4'h3));
    xfer(xw(8'h78, 8'h00, 8'h00, 4'h1));
    chk_bytes(32'ha0207778, 4, 1, 1);
    rd_byte = 8'h96;
    xfer(xw(8'ha1, 8'h00, 8'h00, 4'h6));
    chk("read ack", 32'h1, {31'h0, sl.mst_ack});
    rd_byte = 8'hc5;
    xfer(xw(8'h00, 8'h00, 8'h00, 4'h7));
    apb(1'b0, i2cm_pkg::XFER_OFS, 32'h0);
    chk("single read", 32'hc5, {24'h0, rd[15:8]});
    xfer(xw(8'h00, 8'h00, 8'h00, 4'h1));
    chk("last nack", 32'h0, {31'h0, sl.mst_ack});
    chk_bytes(32'ha1000000, 1, 1, 1);
    apb(1'b1, i2cm_pkg::CTRL_OFS, 32'h2);
    repeat (4) @(posedge pclk);
    chk("sw pins", 32'h2, {30'h0, scl_w, sda_w});
    apb(1'b0, i2cm_pkg::STAT_OFS, 32'h0);
    chk("sw sync", 32'h1, {30'h0, rd[i2cm_pkg::SDAIN_BIT], rd[i2cm_pkg::SCLIN_BIT]});
    apb(1'b1, i2cm_pkg::CTRL_OFS, 32'h4);
    repeat (4) @(posedge pclk);
    chk("sw pins low", 32'h1, {30'h0, scl_w, sda_w});
    chk("drive level", 32'h0, {30'h0, scl_lv, sda_lv});
    stop_test;
  end
endmodule : i2c_master_sequencer_tb
`default_nettype wire
